/* File: logic/nva_pkg.sv */
// nva_pkg: register map, field layout, timing and state types for the
// nonvolatile byte store access unit.
// assumes: one 125 MHz clock; write time counted from the oscillator figure.
package nva_pkg;

    // ==========================================================
    // array geometry (largest variant; smaller ones mask the address)
    localparam int NV_ADDR_W = 11;                  // widest byte address
    localparam int NV_DEPTH  = 2048;                // bytes in the array
    localparam int NV_ADDR_BITS_DEF = 11;           // default variant width

    // ==========================================================
    // register offsets in port-style I/O space
    localparam logic [5:0] OFS_SCRATCH0  = 6'h1E;   // bit-accessible
    localparam logic [5:0] OFS_CONTROL   = 6'h1F;   // bit-accessible
    localparam logic [5:0] OFS_DATA      = 6'h20;
    localparam logic [5:0] OFS_ADDR_LOW  = 6'h21;
    localparam logic [5:0] OFS_ADDR_HIGH = 6'h22;
    localparam logic [5:0] OFS_SCRATCH1  = 6'h2A;
    localparam logic [5:0] OFS_SCRATCH2  = 6'h2B;

    // ==========================================================
    // address spaces
    localparam logic [7:0] IO_PORT_LAST   = 8'h3F;  // last port-style address
    localparam logic [7:0] IO_DATA_OFFSET = 8'h20;  // data space = io + this
    localparam logic [7:0] IO_EXT_FIRST   = 8'h60;  // extended space start
    localparam logic [5:0] IO_BIT_LAST    = 6'h1F;  // last bit-accessible

    // ==========================================================
    // control register bits
    localparam int CTL_READ   = 0;                  // read strobe
    localparam int CTL_STROBE = 1;                  // write strobe
    localparam int CTL_ARM    = 2;                  // write arm
    localparam int CTL_RDY_IE = 3;                  // ready irq enable

    // ==========================================================
    // cycle counts
    localparam logic [2:0] ARM_CYCLES  = 3'h4;      // arm window
    localparam logic [2:0] READ_STALL  = 3'h4;      // cpu halt on read
    localparam logic [2:0] WRITE_STALL = 3'h2;      // cpu halt on write start
    localparam longint WR_OSC_CYCLES   = 27072;     // oscillator cycles
    localparam longint OSC_HZ          = 8000000;   // internal oscillator
    localparam longint CLK_HZ          = 125000000; // block clock
    localparam longint WRITE_CYCLES_DEF = (WR_OSC_CYCLES * CLK_HZ) / OSC_HZ;
    localparam int NV_WTIMER_W = 20;                // holds WRITE_CYCLES_DEF

    // ==========================================================
    // reset values
    localparam logic [7:0] REG_RESET = 8'h00;       // scratch, data, readback

    // ==========================================================
    // sequencing state
    typedef enum logic [2:0] {
        NVA_IDLE  = 3'b001,
        NVA_READ  = 3'b010,
        NVA_WRITE = 3'b100
    } nva_state_type;

    typedef struct packed {
        nva_state_type          state;      // sequencer
        logic [NV_ADDR_W-1:0]   addr;       // byte address
        logic [7:0]             data;       // data byte
        logic                   ready_ie;   // ready irq enable
        logic [2:0]             arm_cnt;    // arm window left
        logic                   strobe;     // write in progress
        logic                   rd_strobe;  // read in progress
        logic [NV_WTIMER_W-1:0] wr_cnt;     // write time left
        logic [2:0]             stall_cnt;  // cpu halt left
        logic                   stall;      // cpu halt output
        logic                   irq;        // ready irq output
        logic [7:0]             rdata;      // read answer output
        logic [2:0][7:0]        scratch;    // scratch registers
    } nva_regs_type;

    localparam nva_regs_type NVA_REGS_RESET = '{state: NVA_IDLE, default: '0};

endpackage : nva_pkg

/* File: logic/nva_mem_if.sv */
// nva_mem_if: port between the access unit and its byte array.
// assumes: array answers a read one clock after rd_en.
`timescale 1ns/100ps
interface nva_mem_if
    import nva_pkg::*;
(
    input wire logic clk
);
    logic                 wr_en;   // store wdata at addr
    logic                 rd_en;   // fetch addr into rdata
    logic [NV_ADDR_W-1:0] addr;
    logic [7:0]           wdata;
    logic [7:0]           rdata;

    modport ctrl (output wr_en, rd_en, addr, wdata, input rdata);
    modport mem  (input clk, wr_en, rd_en, addr, wdata, output rdata);
endinterface : nva_mem_if

/* File: logic/nva_array.sv */
// nva_array: byte array behind the access unit.
// assumes: contents are not reset; read data lands one clock after rd_en.
`timescale 1ns/100ps
module nva_array
    import nva_pkg::*;
(
    nva_mem_if.mem port
);
    // ==========================================================
    // storage: no reset, the cells keep whatever they held
    logic [7:0] cells [NV_DEPTH];

    // one write port and one registered read port
    always_ff @(posedge port.clk) begin
        if (port.wr_en) begin
            cells[port.addr] <= port.wdata;
        end
        if (port.rd_en) begin
            port.rdata <= cells[port.addr];
        end
    end
endmodule : nva_array

/* File: logic/nva_access.sv */
// nva_access: register access unit for the on-chip nonvolatile byte store.
// assumes: the cpu issues one I/O access per cycle and holds off while stalled.
//
// What this block does
// - smallest variant decodes 9-bit address, 0..511
// - larger variants use up to 11 address bits
// - unused address and control bits read zero
// - address resets to zero; software loads it
// - write stores data byte at selected address
// - read loads data byte from selected address
// - ready irq while enabled and strobe clear
// - write starts only inside four-cycle arm window
// - arm bit self-clears after four cycles
// - strobe without arm does nothing
// - read strobe gives data right after
// - read halts cpu for four cycles
// - port space 0x00-0x3F, data space adds 0x20
// - 0x00-0x1F support single-bit set, clear, test
// - bit operations change only the addressed bit
// - extended space only via data-space access
// - three scratch registers hold written values
// - strobe clears when write time elapses
// - write lasts 27072 oscillator cycles
// - during write, reads ignored, address locked
// - write start halts cpu for two cycles
`timescale 1ns/100ps
module nva_access
    import nva_pkg::*;
#(
    parameter int unsigned WRITE_CYCLES = int'(WRITE_CYCLES_DEF), // write time
    parameter int unsigned ADDR_BITS    = NV_ADDR_BITS_DEF        // 9, 10 or 11
) (
    input  wire logic       CLOCK,
    input  wire logic       RESET_N,
    input  wire logic [7:0] IO_ADDR,       // port or data-space address
    input  wire logic       IO_PORT_STYLE, // 1: port-style, 0: data space
    input  wire logic       IO_WR,         // byte write
    input  wire logic       IO_RD,         // byte read
    input  wire logic       IO_BIT_SET,    // single-bit set
    input  wire logic       IO_BIT_CLR,    // single-bit clear
    input  wire logic [2:0] IO_BIT_SEL,    // bit for set or clear
    input  wire logic [7:0] IO_WDATA,
    input  wire logic       GLOBAL_IRQ_EN, // cpu global interrupt flag
    output var  logic [7:0] IO_RDATA,      // answer one clock after IO_RD
    output var  logic       CPU_STALL,     // halt the cpu
    output var  logic       READY_IRQ      // level interrupt
);

    // ==========================================================
    // constants local to this variant
    localparam logic [NV_ADDR_W-1:0] ADDR_MASK =
        NV_ADDR_W'((32'h1 << ADDR_BITS) - 32'h1);
    localparam logic [NV_WTIMER_W-1:0] WTIME = NV_WTIMER_W'(WRITE_CYCLES);

    // ==========================================================
    // state and next state
    nva_regs_type st;              // registered state
    nva_regs_type next_st;         // next value
    logic         hit;             // address maps to this block
    logic [5:0]   io;              // port-style offset
    logic         bitop;           // legal single-bit operation
    logic         ctl_wr;          // control register written
    logic         rd_go;           // read started this cycle
    logic         wr_go;           // write started this cycle
    logic [7:0]   cur;             // addressed register before the access
    logic [7:0]   wval;            // value written after merging a bit op
    logic         mem_wr;          // array write pulse
    logic         mem_rd;          // array read pulse

    nva_mem_if mif (.clk(CLOCK));  // port to the array

    // ==========================================================
    // address decoding: returns {hit, port-style offset}
    function automatic logic [6:0] nva_decode(input logic [7:0] a,
                                              input logic       port);
        logic [7:0] o;
        o = a - IO_DATA_OFFSET;
        if (port) begin
            // port-style reaches only the low 64 locations
            nva_decode = {a <= IO_PORT_LAST, a[5:0]};
        end else if (a >= IO_DATA_OFFSET && a < IO_EXT_FIRST) begin
            nva_decode = {1'b1, o[5:0]};
        end else begin
            // below: cpu working registers; above: extended space
            nva_decode = 7'h00;
        end
    endfunction : nva_decode

    // ==========================================================
    // register readback; reserved bits come back as zero
    function automatic logic [7:0] nva_reg_value(input nva_regs_type s,
                                                 input logic [5:0]   o);
        logic [15:0] a16;
        a16 = 16'(s.addr);
        unique case (o)
            OFS_CONTROL:   nva_reg_value = {4'h0, s.ready_ie, s.arm_cnt != 3'h0,
                                            s.strobe, s.rd_strobe};
            OFS_DATA:      nva_reg_value = s.data;
            OFS_ADDR_LOW:  nva_reg_value = a16[7:0];
            OFS_ADDR_HIGH: nva_reg_value = a16[15:8];
            OFS_SCRATCH0:  nva_reg_value = s.scratch[0];
            OFS_SCRATCH1:  nva_reg_value = s.scratch[1];
            OFS_SCRATCH2:  nva_reg_value = s.scratch[2];
            default:       nva_reg_value = 8'h00;        // unmapped
        endcase
    endfunction : nva_reg_value

    // ==========================================================
    // access decode, shared by the sequencer and the checks
    always_comb begin
        {hit, io} = nva_decode(IO_ADDR, IO_PORT_STYLE);
        cur = nva_reg_value(st, io);
        // bit ops only for port-style offsets 0x00..0x1F
        bitop = (IO_BIT_SET || IO_BIT_CLR) && IO_PORT_STYLE && hit
                && io <= IO_BIT_LAST;
        wval = IO_WDATA;
        if (bitop) begin
            // read-modify-write of one bit; the others rewrite as read
            if (IO_BIT_SET) begin
                wval = cur | (8'h01 << IO_BIT_SEL);
            end else begin
                wval = cur & ~(8'h01 << IO_BIT_SEL);
            end
        end
        ctl_wr = ((IO_WR && hit) || bitop) && io == OFS_CONTROL;
        // the sequencer must be idle, which also ignores reads mid-write
        wr_go = ctl_wr && wval[CTL_STROBE] && st.arm_cnt != 3'h0
                && st.state == NVA_IDLE;
        rd_go = ctl_wr && wval[CTL_READ] && !wval[CTL_STROBE]
                && st.state == NVA_IDLE;
    end

    // ==========================================================
    // next-state logic
    always_comb begin
        next_st = st;
        mem_wr = 1'b0;
        mem_rd = 1'b0;
        // arm window and cpu halt count down every clock
        if (st.arm_cnt != 3'h0) begin
            next_st.arm_cnt = st.arm_cnt - 3'h1;
        end
        if (st.stall_cnt != 3'h0) begin
            next_st.stall_cnt = st.stall_cnt - 3'h1;
        end
        // sequencer
        unique case (st.state)
            NVA_IDLE: begin
                // nothing in flight
            end
            NVA_READ: begin
                // array answered; byte usable as soon as the halt ends
                next_st.data = mif.rdata;
                next_st.rd_strobe = 1'b0;
                next_st.state = NVA_IDLE;
            end
            NVA_WRITE: begin
                if (st.wr_cnt <= 20'h00001) begin
                    // write time over: ready for the next byte
                    next_st.strobe = 1'b0;
                    next_st.state = NVA_IDLE;
                end else begin
                    next_st.wr_cnt = st.wr_cnt - 20'h00001;
                end
            end
            default: begin
                // a corrupted one-hot code recovers to idle
                next_st.state = NVA_IDLE;
            end
        endcase
        // register writes
        if ((IO_WR && hit) || bitop) begin
            unique case (io)
                OFS_CONTROL: begin
                    next_st.ready_ie = wval[CTL_RDY_IE];
                    if (!wval[CTL_ARM]) begin
                        next_st.arm_cnt = 3'h0;
                    end else if (st.arm_cnt == 3'h0) begin
                        // only a fresh arm reloads; a rewrite leaves it
                        next_st.arm_cnt = ARM_CYCLES;
                    end
                    if (wr_go) begin
                        // latch address and data into the array now
                        mem_wr = 1'b1;
                        next_st.strobe = 1'b1;
                        next_st.wr_cnt = WTIME;
                        next_st.stall_cnt = WRITE_STALL;
                        next_st.state = NVA_WRITE;
                    end else if (rd_go) begin
                        mem_rd = 1'b1;
                        next_st.rd_strobe = 1'b1;
                        next_st.stall_cnt = READ_STALL;
                        next_st.state = NVA_READ;
                    end
                end
                OFS_DATA: begin
                    next_st.data = wval;
                end
                OFS_ADDR_LOW: begin
                    if (st.state != NVA_WRITE) begin
                        // masking keeps variant bits above the top at zero
                        next_st.addr[7:0] = wval & ADDR_MASK[7:0];
                    end
                end
                OFS_ADDR_HIGH: begin
                    if (st.state != NVA_WRITE) begin
                        next_st.addr[NV_ADDR_W-1:8] =
                            wval[NV_ADDR_W-9:0] & ADDR_MASK[NV_ADDR_W-1:8];
                    end
                end
                OFS_SCRATCH0: begin
                    next_st.scratch[0] = wval;
                end
                OFS_SCRATCH1: begin
                    next_st.scratch[1] = wval;
                end
                OFS_SCRATCH2: begin
                    next_st.scratch[2] = wval;
                end
                default: begin
                    // unmapped or reserved: write dropped
                end
            endcase
        end
        // outputs, registered so they leave straight from flip-flops
        next_st.stall = next_st.stall_cnt != 3'h0;
        next_st.irq = next_st.ready_ie && GLOBAL_IRQ_EN && !next_st.strobe;
        next_st.rdata = (IO_RD && hit) ? cur : REG_RESET;
    end

    // ==========================================================
    // state register; the address resets to zero though software must
    // still load it, the array contents are not touched by reset
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            st <= NVA_REGS_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // array hookup
    assign mif.wr_en = mem_wr;
    assign mif.rd_en = mem_rd;
    assign mif.addr  = st.addr;
    assign mif.wdata = st.data;

    nva_array u_array (
        .port (mif)
    );

    assign IO_RDATA  = st.rdata;
    assign CPU_STALL = st.stall;
    assign READY_IRQ = st.irq;

    // ==========================================================
    // checks
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RESET_N);

    logic arm_on;                  // arm bit as software sees it
    assign arm_on = st.arm_cnt != 3'h0;

    // a control write in the first armed cycle may legally drop the arm
    property p_arm_clear;
        $rose(arm_on) && !ctl_wr ##1 !ctl_wr [*3] |-> arm_on ##1 !arm_on;
    endproperty
    a_arm_clear: assert property (p_arm_clear)
        else $error("arm bit did not clear after four cycles");

    property p_no_arm_no_write;
        ctl_wr && wval[CTL_STROBE] && !arm_on && !st.strobe |=> !st.strobe;
    endproperty
    a_no_arm_no_write: assert property (p_no_arm_no_write)
        else $error("write started without arm");

    property p_armed_write;
        ctl_wr && wval[CTL_STROBE] && arm_on && st.state == NVA_IDLE
            |=> st.strobe && st.state == NVA_WRITE;
    endproperty
    a_armed_write: assert property (p_armed_write)
        else $error("armed strobe did not start a write");

    property p_write_stall;
        $rose(st.strobe) |-> CPU_STALL [*2] ##1 !CPU_STALL;
    endproperty
    a_write_stall: assert property (p_write_stall)
        else $error("write start halt not two cycles");

    property p_read_stall;
        rd_go |=> CPU_STALL [*4] ##1 !CPU_STALL;
    endproperty
    a_read_stall: assert property (p_read_stall)
        else $error("read halt not four cycles");

    property p_read_data;
        rd_go |-> ##2 st.data == $past(mif.rdata) && !st.rd_strobe;
    endproperty
    a_read_data: assert property (p_read_data)
        else $error("data byte not loaded by read");

    property p_addr_locked;
        st.state == NVA_WRITE |=> $stable(st.addr) && st.state != NVA_READ;
    endproperty
    a_addr_locked: assert property (p_addr_locked)
        else $error("address or read accepted during write");

    property p_write_done;
        st.state == NVA_WRITE && st.wr_cnt == 20'h00001
            |=> !st.strobe && st.state == NVA_IDLE;
    endproperty
    a_write_done: assert property (p_write_done)
        else $error("strobe not cleared at end of write");

    property p_ready_irq;
        st.ready_ie && GLOBAL_IRQ_EN && !st.strobe && !ctl_wr |=> READY_IRQ;
    endproperty
    a_ready_irq: assert property (p_ready_irq)
        else $error("ready interrupt missing");

    // a write still running must keep the ready interrupt quiet
    property p_irq_masked;
        st.strobe && next_st.strobe |=> !READY_IRQ;
    endproperty
    a_irq_masked: assert property (p_irq_masked)
        else $error("ready interrupt raised during a write");

    property p_reserved_zero;
        IO_RD && hit && (io == OFS_CONTROL || io == OFS_ADDR_HIGH)
            |=> IO_RDATA[7:4] == 4'h0 && IO_RDATA[3:0] == $past(cur[3:0]);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits not zero");

    property p_ext_refused;
        IO_RD && IO_PORT_STYLE && IO_ADDR > IO_PORT_LAST |=> IO_RDATA == 8'h00;
    endproperty
    a_ext_refused: assert property (p_ext_refused)
        else $error("port-style access above 0x3F answered");

    c_write: cover property ($fell(st.strobe));
    c_read: cover property (rd_go ##1 CPU_STALL [*4] ##1 !CPU_STALL);
    c_ready_irq: cover property ($rose(READY_IRQ));
    c_bit_set: cover property (bitop && IO_BIT_SET && io == OFS_CONTROL);

endmodule : nva_access

/* File: testbench/nva_cpu_model.sv */
// nva_cpu_model: cpu side, issuing port-style and data-space accesses.
// assumes: the unit samples on rising CLOCK; this model drives on falling.
`timescale 1ns/100ps
module nva_cpu_model (
    input  wire logic       CLOCK,
    input  wire logic       CPU_STALL,
    output var  logic [7:0] IO_ADDR,
    output var  logic       IO_PORT_STYLE,
    output var  logic       IO_WR,
    output var  logic       IO_RD,
    output var  logic       IO_BIT_SET,
    output var  logic       IO_BIT_CLR,
    output var  logic [2:0] IO_BIT_SEL,
    output var  logic [7:0] IO_WDATA
);
    // ==========================================================
    // idle bus; write data is junk unless a write is in flight
    initial begin
        {IO_ADDR, IO_PORT_STYLE, IO_WR, IO_RD} = '0;
        {IO_BIT_SET, IO_BIT_CLR, IO_BIT_SEL} = '0;
        IO_WDATA = 8'hA5;
    end
    // one access: k = {wr, rd, set, clr}; never issued while halted
    task automatic acc(input logic [7:0] a, input logic ps, input logic [3:0] k,
                       input logic [7:0] d);
        @(negedge CLOCK);
        while (CPU_STALL !== 1'b0) @(negedge CLOCK);
        IO_ADDR = a;
        IO_PORT_STYLE = ps;
        IO_WDATA = d;
        IO_BIT_SEL = d[2:0];
        {IO_WR, IO_RD, IO_BIT_SET, IO_BIT_CLR} = k;
        @(negedge CLOCK);
        {IO_WR, IO_RD, IO_BIT_SET, IO_BIT_CLR} = 4'h0;
        // released data shows the inverse, not a held value
        IO_WDATA = ~d;
    endtask : acc
endmodule : nva_cpu_model

/* File: testbench/nva_access_tb_top.sv */
// nva_access_tb_top: self-checking bench for the access unit.
// assumes: cpu model drives the I/O port; reads are scored from a queue.
`timescale 1ns/100ps
module nva_access_tb_top import nva_pkg::*;;
    localparam int unsigned WCYC = 20;  // short write time for simulation
    logic       CLOCK, RESET_N, GLOBAL_IRQ_EN, CPU_STALL, READY_IRQ;
    logic       IO_PORT_STYLE, IO_WR, IO_RD, IO_BIT_SET, IO_BIT_CLR;
    logic [7:0] IO_ADDR, IO_WDATA, IO_RDATA;
    logic [2:0] IO_BIT_SEL;
    logic [7:0] exp_q[$];               // expected read answers, oldest first
    logic       rd_pend;                // a read was taken last edge
    logic [7:0] lfsr, d1;
    int         bad_count, check_count;
    logic [5:0] scr[3];
    logic [7:0] sv[3];                  // values written to the scratch registers
    nva_access #(.WRITE_CYCLES(WCYC), .ADDR_BITS(11)) i_nva_access (
        .CLOCK(CLOCK), .RESET_N(RESET_N), .IO_ADDR(IO_ADDR),
        .IO_PORT_STYLE(IO_PORT_STYLE), .IO_WR(IO_WR), .IO_RD(IO_RD),
        .IO_BIT_SET(IO_BIT_SET), .IO_BIT_CLR(IO_BIT_CLR), .IO_BIT_SEL(IO_BIT_SEL),
        .IO_WDATA(IO_WDATA), .GLOBAL_IRQ_EN(GLOBAL_IRQ_EN), .IO_RDATA(IO_RDATA),
        .CPU_STALL(CPU_STALL), .READY_IRQ(READY_IRQ));
    nva_cpu_model i_nva_cpu_model (
        .CLOCK(CLOCK), .CPU_STALL(CPU_STALL), .IO_ADDR(IO_ADDR),
        .IO_PORT_STYLE(IO_PORT_STYLE), .IO_WR(IO_WR), .IO_RD(IO_RD),
        .IO_BIT_SET(IO_BIT_SET), .IO_BIT_CLR(IO_BIT_CLR), .IO_BIT_SEL(IO_BIT_SEL),
        .IO_WDATA(IO_WDATA));
    // ==========================================================
    // clock, 8 ns period
    initial begin
        CLOCK = 1'b0;
        forever #4 CLOCK = ~CLOCK;
    end
    function automatic logic [7:0] next_rand(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : next_rand
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_byte
    task automatic cmp_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_bit
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_nva_cpu_model.acc(a, 1'b1, 4'h8, d);
    endtask : wr
    // note the answer first, the monitor scores it one cycle later
    task automatic rd(input logic [7:0] a, input logic ps, input logic [7:0] e);
        exp_q.push_back(e);
        i_nva_cpu_model.acc(a, ps, 4'h4, 8'h00);
    endtask : rd
    // count halt cycles, bounded so a stuck halt cannot hang the run
    task automatic stall_len(input logic [7:0] e);
        logic [7:0] n;
        n = 8'h00;
        while (CPU_STALL === 1'b1 && n < 8'h10) begin
            n++;
            @(negedge CLOCK);
        end
        cmp_byte(n, e);
    endtask : stall_len
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : report_and_stop
    // ==========================================================
    // read monitor: answer stands right after the taking edge, scored at the next falling edge
    always @(posedge CLOCK) rd_pend <= IO_RD;
    always @(negedge CLOCK) begin
        if (rd_pend === 1'b1) begin
            cmp_byte(IO_RDATA, exp_q.size() ? exp_q.pop_front() : 8'hEE);
        end
    end
    // watchdog at 20000 cycles; whole sequence takes well under that
    initial begin
        #160000;
        bad_count++;
        report_and_stop();
    end
    // ==========================================================
    // main sequence
    initial begin
        RESET_N = 1'b0;
        GLOBAL_IRQ_EN = 1'b0;
        bad_count = 0;
        check_count = 0;
        lfsr = 8'h43;
        scr = '{OFS_SCRATCH0, OFS_SCRATCH1, OFS_SCRATCH2};
        repeat (6) @(posedge CLOCK);
        @(negedge CLOCK) RESET_N = 1'b1;
        rd(8'(OFS_CONTROL), 1'b1, 8'h00);
        for (int i = 0; i < 3; i++) begin
            rd(8'(scr[i]), 1'b1, REG_RESET);
            lfsr = next_rand(lfsr);
            sv[i] = lfsr;
            wr(8'(scr[i]), lfsr);
            rd(8'(scr[i]) + IO_DATA_OFFSET, 1'b0, lfsr);
        end
        // data-space write of the high address byte, reserved bits set
        i_nva_cpu_model.acc(8'(OFS_ADDR_HIGH) + IO_DATA_OFFSET, 1'b0, 4'h8, 8'hFF);
        rd(8'(OFS_ADDR_HIGH), 1'b1, 8'h07);
        wr(8'(OFS_CONTROL), 8'hF0);
        rd(8'(OFS_CONTROL), 1'b1, 8'h00);
        // single-bit ops touch only their bit, and only below 0x20
        wr(8'(OFS_SCRATCH0), 8'h81);
        i_nva_cpu_model.acc(8'(OFS_SCRATCH0), 1'b1, 4'h2, 8'h03);
        i_nva_cpu_model.acc(8'(OFS_SCRATCH0), 1'b1, 4'h1, 8'h00);
        rd(8'(OFS_SCRATCH0), 1'b1, 8'h88);
        i_nva_cpu_model.acc(8'(OFS_SCRATCH1), 1'b1, 4'h2, 8'h07);
        rd(8'(OFS_SCRATCH1), 1'b1, sv[1]);
        rd(8'h40, 1'b1, 8'h00);
        rd(8'h60, 1'b0, 8'h00);
        // armed write: address then data, arm, strobe inside the window
        wr(8'(OFS_ADDR_HIGH), 8'h05);
        wr(8'(OFS_ADDR_LOW), 8'h3C);
        d1 = next_rand(lfsr);
        wr(8'(OFS_DATA), d1);
        // arm and strobe by single-bit sets, the usual software sequence
        i_nva_cpu_model.acc(8'(OFS_CONTROL), 1'b1, 4'h2, 8'h02);
        i_nva_cpu_model.acc(8'(OFS_CONTROL), 1'b1, 4'h2, 8'h01);
        stall_len(8'(WRITE_STALL));
        rd(8'(OFS_CONTROL), 1'b1, 8'h02);
        wr(8'(OFS_ADDR_LOW), 8'h00);
        repeat (WCYC) @(negedge CLOCK);
        rd(8'(OFS_CONTROL), 1'b1, 8'h00);
        rd(8'(OFS_ADDR_LOW), 1'b1, 8'h3C);
        // read back through the data byte after clobbering it
        wr(8'(OFS_DATA), ~d1);
        wr(8'(OFS_CONTROL), 8'h01);
        stall_len(8'(READ_STALL));
        rd(8'(OFS_DATA), 1'b1, d1);
        // strobe without arm, and strobe after the window closed
        wr(8'(OFS_CONTROL), 8'h02);
        stall_len(8'h00);
        wr(8'(OFS_CONTROL), 8'h04);
        repeat (5) @(negedge CLOCK);
        wr(8'(OFS_CONTROL), 8'h06);
        stall_len(8'h00);
        // the late write found the arm clear, so it only arms afresh
        rd(8'(OFS_CONTROL), 1'b1, 8'h04);
        // ready interrupt follows enable and the global flag
        wr(8'(OFS_CONTROL), 8'h08);
        GLOBAL_IRQ_EN = 1'b1;
        repeat (3) @(negedge CLOCK);
        cmp_bit(READY_IRQ, 1'b1);
        GLOBAL_IRQ_EN = 1'b0;
        repeat (3) @(negedge CLOCK);
        cmp_bit(READY_IRQ, 1'b0);
        // a running write masks the interrupt even when fully enabled
        GLOBAL_IRQ_EN = 1'b1;
        wr(8'(OFS_CONTROL), 8'h0C);
        wr(8'(OFS_CONTROL), 8'h0E);
        stall_len(8'(WRITE_STALL));
        cmp_bit(READY_IRQ, 1'b0);
        repeat (4) @(negedge CLOCK);
        report_and_stop();
    end
endmodule : nva_access_tb_top
